/* File: rtl/sched_pkg.sv */
package sched_pkg;
	// Clock and time base
	localparam int CLK_NS    = 25;        // core_clk period
	localparam int MS_NS     = 1000000;   // One millisecond
	localparam int TICK_CYC  = (MS_NS + CLK_NS - 1) / CLK_NS;
	localparam int N_FRAMES  = 5;         // Status frames
	localparam int PER_W     = 16;        // Period width, ms
	localparam int FIFO_DEPTH = 16;       // Queue depth
	// Default periods, ms
	localparam logic [15:0] PER_GENERAL = 16'h000a; // 10 ms
	localparam logic [15:0] PER_SLOW    = 16'h00a0; // 160 ms
	// Byte offsets
	localparam logic [7:0] OFS_PER0   = 8'h00; // Frame n at +4n
	localparam logic [7:0] OFS_PARAM  = 8'h14;
	localparam logic [7:0] OFS_CFG    = 8'h18;
	localparam logic [7:0] OFS_STAT   = 8'h1c;
	localparam logic [7:0] OFS_TARGET = 8'h20;
	localparam logic [7:0] OFS_SENT   = 8'h24;
	// Parameter write layout
	localparam int PARAM_VAL_BIT = 16;
	// Config register fields
	localparam int CFG_FB_LSB  = 0;  // Feedback select, 4 bits
	localparam int CFG_ZF_BIT  = 4;  // Zero on forward limit
	localparam int CFG_ZR_BIT  = 5;  // Zero on reverse limit
	localparam int CFG_ZI_BIT  = 6;  // Zero on index
	localparam int CFG_POL_BIT = 7;  // Index polarity, inert
	localparam logic [7:0] CFG_RST = 8'h00;
	// Status register fields
	localparam int STAT_LVL_LSB  = 8;
	localparam int STAT_MODE_LSB = 16;
	// Parameter codes
	localparam logic [15:0] FWD_NEW = 16'h0140; // 320
	localparam logic [15:0] FWD_OLD = 16'h0090; // 144
	localparam logic [15:0] REV_NEW = 16'h0141; // 321
	localparam logic [15:0] REV_OLD = 16'h0091; // 145
	localparam logic [15:0] IDX_NEW = 16'h0142; // 322
	localparam logic [15:0] IDX_OLD = 16'h0064; // 100
	localparam logic [15:0] IDX_POL = 16'h0143; // Arbitrary code

	typedef enum logic [2:0] {
		FR_GENERAL, FR_ANALOG, FR_PULSE, FR_TARGETS, FR_PIDF
	} frame_id_e;

	typedef enum logic [2:0] {
		MODE_DUTY, MODE_POSITION, MODE_VELOCITY, MODE_CURRENT,
		MODE_FOLLOWER
	} ctrl_mode_e;

	typedef struct packed {
		logic [1:0]  profile_slot; // Gain slot
		ctrl_mode_e  mode;         // Control mode
		logic        sensor_rev;   // Reverse feedback
		logic        output_rev;   // Reverse output
		logic [31:0] demand;       // Set point, duty or leader
		logic [7:0]  ramp_rate;    // Output ramp
		logic        brake_ovr_en; // Brake override valid
		logic        brake_ovr;    // Brake override value
		logic        limit_ovr_en; // Limit override valid
		logic        limit_ovr;    // Limit override value
	} cmd_frame_s;

	typedef struct packed {
		logic signed [9:0] motor_out; // -512..+511
		logic [7:0]  faults;
		logic [15:0] an_pos, an_vel;
		logic [7:0]  temp, batt;
		logic [15:0] pw_period, pw_high, pw_pos, pw_vel;
		logic [31:0] tgt_pos;
		logic [15:0] tgt_vel, tgt_head;
		logic [23:0] pid_err, pid_iacc;
		logic [15:0] pid_deriv;
	} sensor_s;

	typedef struct packed {
		frame_id_e   id;      // Which frame
		logic [63:0] payload; // Frame body
	} tx_frame_s;
endpackage

/* File: rtl/sync_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
	parameter int W = 3,  // Word width
	parameter int D = 16  // Depth
) (
	input  wire logic             core_clk,  // Clock
	input  wire logic             rstn,      // Async reset, low
	input  wire logic             in_valid,  // Push request
	output logic                  in_ready,  // Not full
	input  wire logic [W-1:0]     in_data,   // Push word
	output logic                  out_valid, // Not empty
	input  wire logic             out_ready, // Pop request
	output logic [W-1:0]          out_data,  // Head word
	output logic [$clog2(D):0]    level      // Words held
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];   // Storage, no reset needed
	logic [AW-1:0] wr_ptr;    // Next write slot
	logic [AW-1:0] rd_ptr;    // Head slot
	logic          push;      // Accepted write
	logic          pop;       // Accepted read

	assign in_ready  = level != (AW+1)'(D);
	assign out_valid = level != '0;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr];

	// Storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop) rd_ptr <= rd_ptr + 1'b1;
			level <= level + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

/* File: rtl/frame_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module frame_timer #(
	parameter int W = 16  // Period width
) (
	input  wire logic         core_clk, // Clock
	input  wire logic         rstn,     // Async reset, low
	input  wire logic         tick,     // Millisecond strobe
	input  wire logic [W-1:0] period,   // Reload value, ms
	output logic              expire    // One-cycle pulse
);
	logic [W-1:0] cnt; // Remaining ms

	// Down-count on each tick; a zero period acts as one ms
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt    <= '0;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (tick) begin
				if (cnt <= W'(1)) begin
					cnt    <= period;
					expire <= 1'b1;
				end else begin
					cnt <= cnt - 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/motor_ctrl_frame_scheduler.sv */
// Functional notes
// R1: Analog status frame every 160 ms default
// R2: Converter always running, values always reported
// R3: Pulse-width status frame every 160 ms default
// R4: Trajectory target frame every 160 ms default
// R5: Closed-loop terms frame every 160 ms default
// R6: Host may change any frame period
// R7: Host sends command frame, default 10 ms
// R8: Command frame carries slot, mode, flags, overrides
// R9: Command period set by host only, no timeout
// R10: Index zeroing on rising edge only
// R11: Both parameter codes accepted per zero setting
// R12: Current mode target reported in milliamperes
// R13: General status frame every 10 ms default
// R14: Periods return to defaults after reset
// R15: Per-frame ms down-counter queues frame on expiry
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_frame_scheduler
	import sched_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC  // Cycles per ms
) (
	input  wire logic        core_clk,        // 40 MHz clock
	input  wire logic        rstn,            // Async reset, low
	input  wire logic [7:0]  avs_address,     // Byte address
	input  wire logic        avs_read,        // Read request
	input  wire logic        avs_write,       // Write request
	input  wire logic [31:0] avs_writedata,   // Write data
	input  wire logic [3:0]  avs_byteenable,  // Byte lanes
	output logic [31:0]      avs_readdata,    // Read data
	output logic             avs_waitrequest, // Stall
	input  wire logic        index_pin,       // Encoder index pin
	input  wire logic        fwd_limit_n,     // Fwd limit, low closed
	input  wire logic        rev_limit_n,     // Rev limit, low closed
	input  wire sensor_s     sensors,         // Live sensor values
	input  wire logic        cmd_valid,       // Command frame strobe
	input  wire cmd_frame_s  cmd,             // Command frame body
	output cmd_frame_s       cmd_out,         // Latched command
	output logic             tx_valid,        // Frame ready to send
	input  wire logic        tx_ready,        // Transmitter takes it
	output tx_frame_s        tx_frame,        // Frame to send
	output logic             pos_clear,       // Zero position pulse
	output logic             adc_run          // Converter enable
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// Lowest pending frame wins the queue slot
	function automatic frame_id_e pick(input logic [N_FRAMES-1:0] p);
		pick = FR_GENERAL;
		for (int i = N_FRAMES - 1; i >= 0; i--) begin
			if (p[i]) pick = frame_id_e'(3'(i));
		end
	endfunction

	// Merge the two low byte lanes of a write
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = old;
		if (be[0]) merge16[7:0] = wd[7:0];
		if (be[1]) merge16[15:8] = wd[15:8];
	endfunction

	logic [15:0]          period [N_FRAMES]; // Per-frame period, ms
	logic [N_FRAMES-1:0]  expire;            // Timer pulses
	logic [N_FRAMES-1:0]  pend;              // Waiting for queue
	logic [N_FRAMES-1:0]  next_pend;         // Pending next value
	logic [31:0]          tick_cnt;          // Tick prescaler
	logic                 tick;              // One-ms strobe
	logic                 ack;               // Bus answer cycle
	logic                 do_wr;             // Write commits
	logic [7:0]           cfg;               // Config register
	logic [31:0]          sent;              // Frames sent
	logic                 q_in_ready;        // Queue has room
	logic                 q_out_valid;       // Queue has a frame
	logic                 q_out_ready;       // Output stage free
	logic [2:0]           q_out_data;        // Queued frame id
	logic [LW-1:0]        q_level;           // Queue fill
	logic                 q_push;            // Frame enters queue
	logic [2:0]           s1;                // Pin sync stage 1
	logic [2:0]           s2;                // Pin sync stage 2
	logic [2:0]           s3;                // Previous synced
	logic [63:0]          next_payload;      // Payload to load

	// Millisecond tick from core_clk
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			tick     <= 1'b0;
		end
	end

	// One independent down-counter per status frame
	for (genvar g = 0; g < N_FRAMES; g++) begin : g_tmr
		frame_timer #(.W(PER_W)) u_tmr (
			.core_clk (core_clk),
			.rstn     (rstn),
			.tick     (tick),
			.period   (period[g]),
			.expire   (expire[g])  // [R15]
		);
	end

	// Pending flags; a fresh expiry beats the queue clear
	always_comb begin
		next_pend = pend;
		if (q_push) next_pend[pick(pend)] = 1'b0;
		next_pend = next_pend | expire; // [R15]
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pend <= '0;
		end else begin
			pend <= next_pend;
		end
	end

	// Queue stalls when full; pending bits hold the backlog
	assign q_push = |pend & q_in_ready;

	sync_fifo #(.W(3), .D(FIFO_DEPTH)) u_q (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.in_valid  (|pend),
		.in_ready  (q_in_ready),
		.in_data   (pick(pend)),
		.out_valid (q_out_valid),
		.out_ready (q_out_ready),
		.out_data  (q_out_data),
		.level     (q_level)
	);

	// Bus: answer one cycle after the request appears
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign do_wr = avs_write & ack;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read | avs_write) & ~ack;
		end
	end

	// Period registers; reset always restores defaults
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			period[FR_GENERAL] <= PER_GENERAL; // [R13] [R14]
			period[FR_ANALOG]  <= PER_SLOW;    // [R1]
			period[FR_PULSE]   <= PER_SLOW;    // [R3]
			period[FR_TARGETS] <= PER_SLOW;    // [R4]
			period[FR_PIDF]    <= PER_SLOW;    // [R5]
		end else if (do_wr) begin
			for (int i = 0; i < N_FRAMES; i++) begin
				if (avs_address == OFS_PER0 + 8'(4 * i)) begin
					period[i] <= merge16(period[i], avs_writedata,
						avs_byteenable); // [R6]
				end
			end
		end
	end

	// Config: direct write or by parameter code
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg <= CFG_RST;
		end else if (do_wr && avs_byteenable[0]) begin
			if (avs_address == OFS_CFG) begin
				cfg <= avs_writedata[7:0];
			end else if (avs_address == OFS_PARAM) begin
				unique case (avs_writedata[15:0])
					FWD_NEW, FWD_OLD:
						cfg[CFG_ZF_BIT] <= avs_writedata[PARAM_VAL_BIT]; // [R11]
					REV_NEW, REV_OLD:
						cfg[CFG_ZR_BIT] <= avs_writedata[PARAM_VAL_BIT]; // [R11]
					IDX_NEW, IDX_OLD:
						cfg[CFG_ZI_BIT] <= avs_writedata[PARAM_VAL_BIT]; // [R11]
					IDX_POL:
						cfg[CFG_POL_BIT] <= avs_writedata[PARAM_VAL_BIT];
					default: ; // Unknown codes ignored
				endcase
			end
		end
	end

	// Read data loads in the stall cycle, stands at the answer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= '0;
		end else if (avs_read && !ack) begin
			avs_readdata <= '0;
			for (int i = 0; i < N_FRAMES; i++) begin
				if (avs_address == OFS_PER0 + 8'(4 * i)) begin
					avs_readdata <= {16'h0000, period[i]};
				end
			end
			unique case (avs_address)
				OFS_CFG: avs_readdata <= {24'h000000, cfg};
				OFS_STAT: begin
					avs_readdata[N_FRAMES-1:0] <= pend;
					avs_readdata[STAT_LVL_LSB +: LW] <= q_level;
					avs_readdata[STAT_MODE_LSB +: 3] <= cmd_out.mode;
				end
				// Current mode demand is held in mA already
				OFS_TARGET: avs_readdata <= cmd_out.demand; // [R12]
				OFS_SENT: avs_readdata <= sent;
				default: ; // Periods above, rest reads zero
			endcase
		end
	end

	// Command frame latch; no timeout, host sets the pace
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_out <= '0;
		end else if (cmd_valid) begin
			cmd_out <= cmd; // [R8] [R9]
		end
	end

	// Converter stays on from reset onward
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			adc_run <= 1'b0;
		end else begin
			adc_run <= 1'b1; // [R2]
		end
	end

	// Pin synchronisers: index, fwd, rev
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s1 <= 3'h6;
			s2 <= 3'h6;
			s3 <= 3'h6;
		end else begin
			s1 <= {rev_limit_n, fwd_limit_n, index_pin};
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Position zero; polarity bit kept but never used
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pos_clear <= 1'b0;
		end else begin
			pos_clear <= (cfg[CFG_ZI_BIT] & s2[0] & ~s3[0]) // [R10]
				| (cfg[CFG_ZF_BIT] & ~s2[1] & s3[1])
				| (cfg[CFG_ZR_BIT] & ~s2[2] & s3[2]);
		end
	end

	// Build the body of the frame at the head of the queue
	always_comb begin
		unique case (frame_id_e'(q_out_data))
			FR_GENERAL: next_payload = {41'h0, sensors.motor_out,
				~s2[1], ~s2[2], sensors.faults, cmd_out.mode}; // [R13]
			FR_ANALOG: next_payload = {sensors.an_pos, sensors.an_vel,
				sensors.temp, sensors.batt, 12'h000,
				cfg[CFG_FB_LSB +: 4]}; // [R1]
			FR_PULSE: next_payload = {sensors.pw_period,
				sensors.pw_high, sensors.pw_vel, sensors.pw_pos}; // [R3]
			FR_TARGETS: next_payload = {sensors.tgt_pos,
				sensors.tgt_vel, sensors.tgt_head}; // [R4]
			FR_PIDF: next_payload = {sensors.pid_err,
				sensors.pid_iacc, sensors.pid_deriv}; // [R5]
			default: next_payload = '0; // Ids 5..7 never queued
		endcase
	end

	// Output stage: refill when empty or being taken
	assign q_out_ready = ~tx_valid | tx_ready;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_valid <= 1'b0;
			tx_frame <= '0;
		end else if (q_out_ready) begin
			tx_valid <= q_out_valid;
			if (q_out_valid) begin
				tx_frame.id      <= frame_id_e'(q_out_data);
				tx_frame.payload <= next_payload;
			end
		end
	end

	// Count frames handed to the transmitter
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sent <= '0;
		end else if (tx_valid && tx_ready) begin
			sent <= sent + 32'h0000_0001;
		end
	end
endmodule
`default_nettype wire

/* File: verification/sched_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sched_monitor
	import sched_pkg::*;
(
	input wire logic       core_clk,        // Clock
	input wire logic       rstn,            // Reset, low
	input wire logic       avs_read,        // Read request
	input wire logic       avs_write,       // Write request
	input wire logic       avs_waitrequest, // Stall
	input wire logic       index_pin,       // Index pin
	input wire logic       fwd_limit_n,     // Fwd limit
	input wire logic       rev_limit_n,     // Rev limit
	input wire logic       cmd_valid,       // Command strobe
	input wire cmd_frame_s cmd,             // Command body
	input wire cmd_frame_s cmd_out,         // Latched command
	input wire logic       tx_valid,        // Frame offered
	input wire logic       tx_ready,        // Frame taken
	input wire tx_frame_s  tx_frame,        // Frame
	input wire logic       pos_clear,       // Zero pulse
	input wire logic       adc_run          // Converter on
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire logic req = avs_read | avs_write; // Any bus request
	// Converter never pauses once out of reset
	a_adc_always_on: assert property ($past(rstn) |-> adc_run)
		else $error("converter stopped");
	// Exactly one stall cycle per access
	a_wait_one: assert property ($rose(req) |->
		avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one cycle");
	a_wait_idle: assert property (!req |-> !avs_waitrequest)
		else $error("stall while idle");
	// Offered frame must not change before it is taken
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_frame))
		else $error("frame dropped or changed");
	a_cmd_latch: assert property (cmd_valid |=>
		cmd_out == $past(cmd))
		else $error("command not latched");
	// Window of 2..5 cycles covers the sync delay either way
	a_zero_cause: assert property (pos_clear |->
		($past(index_pin, 2) && !$past(index_pin, 5)) ||
		(!$past(fwd_limit_n, 2) && $past(fwd_limit_n, 5)) ||
		(!$past(rev_limit_n, 2) && $past(rev_limit_n, 5)))
		else $error("zero without rising index or closing limit");
	a_zero_pulse: assert property (pos_clear |=> !pos_clear)
		else $error("zero pulse too long");
	a_general_body: assert property (tx_valid &&
		tx_frame.id == FR_GENERAL |-> tx_frame.payload[63:23] == '0)
		else $error("general frame spare bits set");
	a_analog_body: assert property (tx_valid &&
		tx_frame.id == FR_ANALOG |-> tx_frame.payload[15:4] == '0)
		else $error("analog frame spare bits set");
	c_taken: cover property (tx_valid && tx_ready);
	c_stall: cover property (tx_valid && !tx_ready);
	c_zero: cover property (pos_clear);
	c_cmd: cover property (cmd_valid);
endmodule
bind motor_ctrl_frame_scheduler sched_monitor u_sched_monitor (
	.core_clk, .rstn, .avs_read, .avs_write, .avs_waitrequest, .index_pin,
	.fwd_limit_n, .rev_limit_n, .cmd_valid, .cmd, .cmd_out, .tx_valid,
	.tx_ready, .tx_frame, .pos_clear, .adc_run);
`default_nettype wire

/* File: verification/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model
	import sched_pkg::*;
#(
	parameter int CMD_CYC = 40 // Command spacing, cycles
) (
	input wire logic  core_clk,  // Clock
	input wire logic  rstn,      // Reset, low
	input wire logic  cmd_en,    // Send commands
	input wire logic  stall_en,  // Allow sink stalls
	output cmd_frame_s cmd,      // Command body
	output logic      cmd_valid, // Command strobe
	output logic      tx_ready   // Sink ready
);
	logic [31:0] rnd; // Own random state
	logic [15:0] gap; // Cycles to next command
	// Free-running sender, no reply awaited, no timeout
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rnd <= 32'h00001357;
			gap <= 16'h0000;
			cmd_valid <= 1'b0;
			cmd <= '0;
			tx_ready <= 1'b0;
		end else begin
			rnd <= {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
			// Sink stalls about one cycle in four when allowed
			tx_ready <= !stall_en || rnd[3:2] != 2'b00;
			cmd_valid <= cmd_en && gap == 16'h0000;
			gap <= (gap == 16'h0000) ? 16'(CMD_CYC - 1) : gap - 16'h0001;
			// Slot, mode, flags, demand, ramp, overrides
			if (cmd_en && gap == 16'h0000)
				cmd <= {rnd[1:0], 3'(rnd[6:3] % 5), rnd[8:7], rnd,
					rnd[16:9], rnd[20:17]};
		end
	end
endmodule
`default_nettype wire

/* File: verification/tb_motor_ctrl_frame_scheduler.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_motor_ctrl_frame_scheduler
	import sched_pkg::*;
;
	localparam int TK = 4; // Cycles per ms here
	logic        core_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0;
	logic        avs_write = 1'b0, index_pin = 1'b0, cmd_en = 1'b0;
	logic        fwd_limit_n = 1'b1, rev_limit_n = 1'b1, stall_en = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rq, rd;
	logic [3:0]  avs_byteenable = 4'hf, fb;
	logic        avs_waitrequest, cmd_valid, tx_valid, tx_ready, wq;
	logic        pos_clear, adc_run;
	logic [31:0] seed = 32'h400d;     // Random state
	logic [287:0] pool = '0;          // Sensor fill
	sensor_s     sensors = '0;        // Live values
	cmd_frame_s  cmd, cmd_out;        // Command in, out
	tx_frame_s   tx_frame;            // Frame out
	logic [15:0] codes [6] = '{FWD_NEW, FWD_OLD, REV_NEW, REV_OLD,
		IDX_NEW, IDX_OLD};
	int          mismatches = 0, compares = 0, cyc = 0, nclr = 0;
	int          cnt [5];             // Frames taken per id
	motor_ctrl_frame_scheduler #(.TICK_CYCLES(TK)) u_motor_ctrl_frame_scheduler (
		.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.index_pin, .fwd_limit_n, .rev_limit_n, .sensors, .cmd_valid, .cmd,
		.cmd_out, .tx_valid, .tx_ready, .tx_frame, .pos_clear, .adc_run);
	host_model #(.CMD_CYC(10 * TK)) u_host_model (.core_clk, .rstn, .cmd_en,
		.stall_en, .cmd, .cmd_valid, .tx_ready);
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= rstn ? cyc + 1 : 0;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Frame body expected from the held sensor values
	function automatic logic [63:0] exp_pay(input frame_id_e id);
		case (id)
			FR_ANALOG: exp_pay = {sensors.an_pos, sensors.an_vel, sensors.temp,
				sensors.batt, 12'h000, fb};
			FR_PULSE: exp_pay = {sensors.pw_period, sensors.pw_high,
				sensors.pw_vel, sensors.pw_pos};
			FR_TARGETS: exp_pay = {sensors.tgt_pos, sensors.tgt_vel,
				sensors.tgt_head};
			default: exp_pay = {sensors.pid_err, sensors.pid_iacc,
				sensors.pid_deriv};
		endcase
	endfunction
	task automatic give_verdict;
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Settled values sampled mid-cycle, so edge order never matters
	always @(negedge core_clk) begin
		wq <= avs_waitrequest;
		rq <= avs_readdata;
		if (rstn && pos_clear === 1'b1)
			nclr <= nclr + 1;
		if (rstn && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			cnt[tx_frame.id] <= cnt[tx_frame.id] + 1;
			if (tx_frame.id != FR_GENERAL)
				chk("payload", exp_pay(tx_frame.id), tx_frame.payload);
			else
				chk("general", {sensors.motor_out, sensors.faults},
					{tx_frame.payload[22:13], tx_frame.payload[10:3]});
		end
	end
	// One Avalon access; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wq !== 1'b0 && n < 50);
		rd = rq;
		if (n >= 50) begin
			mismatches++;
			give_verdict();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rst_dut;
		rstn <= 1'b0;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
	endtask
	// Move one pin with a zeroing setup, count pulses that follow
	task automatic pin(input int p, input logic lv, input logic [3:0] z,
		input int e);
		int n0;
		bus(1'b1, OFS_CFG, {24'h0, z, fb});
		n0 = nclr;
		if (p == 0) index_pin <= lv;
		else if (p == 1) fwd_limit_n <= lv;
		else rev_limit_n <= lv;
		repeat (8) @(posedge core_clk);
		chk("zero pulses", e, nclr - n0);
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		give_verdict();
	end
	initial begin
		int n, c0;
		foreach (cnt[i]) cnt[i] = 0;
		for (int i = 0; i < 9; i++) begin
			pool = {pool[255:0], seed};
			seed = lfsr(seed);
		end
		sensors = pool[$bits(sensor_s)-1:0];
		fb = seed[3:0];
		rst_dut();
		// Feedback select must be in place before the first analog frame
		bus(1'b1, OFS_CFG, {28'h0, fb});
		cmd_en <= 1'b1;
		stall_en <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 8'(4 * i), 32'h0);
			chk("period", i == 0 ? PER_GENERAL : PER_SLOW, rd);
		end
		bus(1'b0, 8'h30, 32'h0);
		chk("unmapped", 0, rd);
		// 199 ticks: general at 1,11..191, slow ones at 1 and 161
		while (cyc < 798) @(posedge core_clk);
		chk("general count", 20, cnt[0]);
		for (int i = 1; i < 5; i++)
			chk("slow count", 2, cnt[i]);
		for (int i = 0; i < 12; i++) begin
			bus(1'b1, OFS_PARAM, {15'h0, !i[0], codes[i / 2]});
			bus(1'b0, OFS_CFG, 32'h0);
			chk("param", {i[0] ? 4'h0 : 4'(1 << (i / 4)), fb}, rd[7:0]);
		end
		// Polarity code is stored but must not change index zeroing
		bus(1'b1, OFS_PARAM, {15'h0, 1'b1, IDX_POL});
		bus(1'b0, OFS_CFG, 32'h0);
		chk("polarity", {4'h8, fb}, rd[7:0]);
		// Faster analog rate takes hold at its next reload
		bus(1'b1, OFS_PER0 + 8'h04, 32'h3);
		c0 = cnt[1];
		n = 0;
		while (cnt[1] < c0 + 2 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		foreach (cnt[i]) cnt[i] = 0;
		repeat (30 * TK) @(posedge core_clk);
		chk("analog rate", 1, n < 3000 && cnt[1] >= 9 && cnt[1] <= 11);
		cmd_en <= 1'b0;
		repeat (50) @(posedge core_clk);
		bus(1'b0, OFS_TARGET, 32'h0);
		chk("target", cmd.demand, rd);
		bus(1'b0, OFS_STAT, 32'h0);
		chk("mode", cmd.mode, rd[18:16]);
		chk("cmd_out", cmd, cmd_out);
		pin(0, 1'b1, 4'b0100, 1);
		pin(0, 1'b0, 4'b0100, 0);
		pin(0, 1'b1, 4'b1100, 1);
		pin(0, 1'b0, 4'b1100, 0);
		pin(1, 1'b0, 4'b0001, 1);
		pin(1, 1'b1, 4'b0001, 0);
		pin(2, 1'b0, 4'b0010, 1);
		pin(2, 1'b1, 4'b0010, 0);
		pin(0, 1'b1, 4'b0000, 0);
		rst_dut();
		bus(1'b1, OFS_CFG, {28'h0, fb});
		bus(1'b0, OFS_PER0 + 8'h04, 32'h0);
		chk("period after reset", PER_SLOW, rd);
		// First tick queues all five frames; next one is ten ms away
		repeat (30) @(posedge core_clk);
		bus(1'b0, OFS_SENT, 32'h0);
		chk("sent", 5, rd);
		give_verdict();
	end
endmodule
`default_nettype wire
